// File: hw/ptc_map.vh
// Purpose: Offsets, field positions and reset values of the calibration bank
// Assumes: 8-bit register addresses, 24-bit register data
// Notes:   Included by the bank and by the register cell
`ifndef PTC_MAP_VH
`define PTC_MAP_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define PTC_TX2_HI_REF_COEFF_OFS 8'h45
`define PTC_TX2_HI_EXT_COEFF_OFS 8'h46
`define PTC_TX0_LO_REF_OFS 8'h47
`define PTC_TX0_HI_REF_OFS 8'h48
`define PTC_TX1_LO_REF_OFS 8'h49
`define PTC_FIRST_OFS 8'h45
`define PTC_NUM_REGS 5

// ---------------------------------------------------------------
// Field layout and reset values
// ---------------------------------------------------------------
`define PTC_DATA_W 24
`define PTC_FIELD_W 12
`define PTC_HI_FIELD_MSB 23
`define PTC_HI_FIELD_LSB 12
`define PTC_LO_FIELD_MSB 11
`define PTC_LO_FIELD_LSB 0
`define PTC_ZERO_RST 24'h000000
`define PTC_TX0_LO_RST 24'h800800
`define PTC_READ_ZERO 24'h000000

`endif

// File: hw/ptc_reg_cell.v
// Purpose: One 24-bit read/write calibration register with its own reset value
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Reset value is a parameter so one cell serves every register
`timescale 1ns/1ns
`include "ptc_map.vh"

module ptc_reg_cell #(
  parameter [`PTC_DATA_W-1:0] RESET_VALUE = `PTC_ZERO_RST
) (
  // Clock and reset
  input wire mclk_in,
  input wire rst_n_in,
  // Write side
  input wire wr_sel_in,
  input wire [`PTC_DATA_W-1:0] wdata_in,
  // Stored value
  output wire [`PTC_DATA_W-1:0] value_out
);

  reg [`PTC_DATA_W-1:0] value_reg;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // Holds the last written word, or the reset value until a write
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      value_reg <= RESET_VALUE;
    end else if (wr_sel_in) begin
      value_reg <= wdata_in;
    end
  end

  assign value_out = value_reg;

endmodule // ptc_reg_cell

// File: hw/ptc_calib_regs.v
// Purpose: Phase temperature calibration register bank, offsets 45h to 49h
// Assumes: Internal register port from the serial host interface, same clock
// Notes:   Read data is registered; unmapped reads return zero
`timescale 1ns/1ns
`include "ptc_map.vh"

module ptc_calib_regs #(
  parameter NUM_REGS = `PTC_NUM_REGS
) (
  // Clock and reset
  input wire mclk_in,
  input wire rst_n_in,
  // Register port from the host interface
  input wire [7:0] addr_in,
  input wire wr_en_in,
  input wire rd_en_in,
  input wire [`PTC_DATA_W-1:0] wdata_in,
  output reg [`PTC_DATA_W-1:0] rdata_out,
  output reg rvalid_out,
  output wire hit_out,
  // Correction enable, driven by the neighbouring control register
  input wire temp_correction_enable_in,
  // Values towards the phase correction datapath
  output wire temp_corr_active_out,
  output reg [`PTC_FIELD_W-1:0] onchip_ref_temp_ch2_high_out,
  output reg [`PTC_FIELD_W-1:0] onchip_phase_coeff_ch0_low_out,
  output reg [`PTC_FIELD_W-1:0] ext_ref_temp_ch2_high_out,
  output reg [`PTC_FIELD_W-1:0] ext_phase_coeff_ch0_low_out,
  output reg [`PTC_FIELD_W-1:0] ext_ref_temp_ch0_low_out,
  output reg [`PTC_FIELD_W-1:0] onchip_ref_temp_ch0_low_out,
  output reg [`PTC_FIELD_W-1:0] ext_ref_temp_ch0_high_out,
  output reg [`PTC_FIELD_W-1:0] onchip_ref_temp_ch0_high_out,
  output reg [`PTC_FIELD_W-1:0] ext_ref_temp_ch1_low_out,
  output reg [`PTC_FIELD_W-1:0] onchip_ref_temp_ch1_low_out
);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // Index of an offset inside the bank; used by the write and read paths
  function [2:0] bank_index;
    input [7:0] addr;
    reg [7:0] diff;
    begin
      diff = addr - `PTC_FIRST_OFS;
      bank_index = diff[2:0];
    end
  endfunction

  // True when the offset falls on one of the five registers
  function bank_hit;
    input [7:0] addr;
    begin
      bank_hit = (addr >= `PTC_FIRST_OFS) && (addr <= `PTC_TX1_LO_REF_OFS);
    end
  endfunction

  wire [2:0] sel_index;
  wire [`PTC_DATA_W*NUM_REGS-1:0] bank_flat;
  reg [`PTC_DATA_W-1:0] rd_word;

  assign sel_index = bank_index(addr_in);
  assign hit_out = bank_hit(addr_in);

  // ---------------------------------------------------------------
  // Register cells
  // ---------------------------------------------------------------
  // Only offset 47h comes out of reset non-zero; every other cell clears
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g = g + 1) begin : g_cell
      localparam [`PTC_DATA_W-1:0] CELL_RST =
        (g == (`PTC_TX0_LO_REF_OFS - `PTC_FIRST_OFS)) ? `PTC_TX0_LO_RST : `PTC_ZERO_RST;
      ptc_reg_cell #(
        .RESET_VALUE(CELL_RST)
      ) u_cell (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .wr_sel_in(wr_en_in && hit_out && (sel_index == g)),
        .wdata_in(wdata_in),
        .value_out(bank_flat[g*`PTC_DATA_W +: `PTC_DATA_W])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Unmapped offsets read zero so a stray host read stays harmless
  always @* begin
    if (hit_out) begin
      rd_word = bank_flat[sel_index*`PTC_DATA_W +: `PTC_DATA_W];
    end else begin
      rd_word = `PTC_READ_ZERO;
    end
  end

  // Data registered one cycle after the strobe; a same-cycle write shows next read
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= `PTC_READ_ZERO;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= rd_en_in;
      if (rd_en_in) begin
        rdata_out <= rd_word;
      end
    end
  end

  // ---------------------------------------------------------------
  // Field outputs
  // ---------------------------------------------------------------
  // Coefficients are forced to zero while correction is off, so the datapath
  // applies no temperature term; loading order is left to the host
  assign temp_corr_active_out = temp_correction_enable_in;

  wire [`PTC_DATA_W-1:0] r45 = bank_flat[0*`PTC_DATA_W +: `PTC_DATA_W];
  wire [`PTC_DATA_W-1:0] r46 = bank_flat[1*`PTC_DATA_W +: `PTC_DATA_W];
  wire [`PTC_DATA_W-1:0] r47 = bank_flat[2*`PTC_DATA_W +: `PTC_DATA_W];
  wire [`PTC_DATA_W-1:0] r48 = bank_flat[3*`PTC_DATA_W +: `PTC_DATA_W];
  wire [`PTC_DATA_W-1:0] r49 = bank_flat[4*`PTC_DATA_W +: `PTC_DATA_W];

  // Registered copies keep the datapath away from the host decode timing
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      onchip_ref_temp_ch2_high_out <= {`PTC_FIELD_W{1'b0}};
      onchip_phase_coeff_ch0_low_out <= {`PTC_FIELD_W{1'b0}};
      ext_ref_temp_ch2_high_out <= {`PTC_FIELD_W{1'b0}};
      ext_phase_coeff_ch0_low_out <= {`PTC_FIELD_W{1'b0}};
      ext_ref_temp_ch0_low_out <= {`PTC_FIELD_W{1'b0}};
      onchip_ref_temp_ch0_low_out <= {`PTC_FIELD_W{1'b0}};
      ext_ref_temp_ch0_high_out <= {`PTC_FIELD_W{1'b0}};
      onchip_ref_temp_ch0_high_out <= {`PTC_FIELD_W{1'b0}};
      ext_ref_temp_ch1_low_out <= {`PTC_FIELD_W{1'b0}};
      onchip_ref_temp_ch1_low_out <= {`PTC_FIELD_W{1'b0}};
    end else begin
      onchip_ref_temp_ch2_high_out <= r45[`PTC_HI_FIELD_MSB:`PTC_HI_FIELD_LSB];
      ext_ref_temp_ch2_high_out <= r46[`PTC_HI_FIELD_MSB:`PTC_HI_FIELD_LSB];
      if (temp_correction_enable_in) begin
        onchip_phase_coeff_ch0_low_out <= r45[`PTC_LO_FIELD_MSB:`PTC_LO_FIELD_LSB];
        ext_phase_coeff_ch0_low_out <= r46[`PTC_LO_FIELD_MSB:`PTC_LO_FIELD_LSB];
      end else begin
        onchip_phase_coeff_ch0_low_out <= {`PTC_FIELD_W{1'b0}};
        ext_phase_coeff_ch0_low_out <= {`PTC_FIELD_W{1'b0}};
      end
      ext_ref_temp_ch0_low_out <= r47[`PTC_HI_FIELD_MSB:`PTC_HI_FIELD_LSB];
      onchip_ref_temp_ch0_low_out <= r47[`PTC_LO_FIELD_MSB:`PTC_LO_FIELD_LSB];
      ext_ref_temp_ch0_high_out <= r48[`PTC_HI_FIELD_MSB:`PTC_HI_FIELD_LSB];
      onchip_ref_temp_ch0_high_out <= r48[`PTC_LO_FIELD_MSB:`PTC_LO_FIELD_LSB];
      ext_ref_temp_ch1_low_out <= r49[`PTC_HI_FIELD_MSB:`PTC_HI_FIELD_LSB];
      onchip_ref_temp_ch1_low_out <= r49[`PTC_LO_FIELD_MSB:`PTC_LO_FIELD_LSB];
    end
  end

endmodule // ptc_calib_regs

// File: verif/ptc_calib_regs_chk.sv
// Purpose: Port assertions for the calibration bank
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound from the testbench top file
`timescale 1ns/1ns
module ptc_calib_regs_chk #(parameter NUM_REGS = 5) (
  // Watched ports
  input wire mclk_in, rst_n_in, rd_en_in, rvalid_out, hit_out,
  input wire temp_correction_enable_in, temp_corr_active_out,
  input wire [7:0] addr_in,
  input wire [23:0] rdata_out,
  input wire [11:0] onchip_phase_coeff_ch0_low_out, ext_phase_coeff_ch0_low_out,
  input wire [11:0] ext_ref_temp_ch0_low_out, onchip_ref_temp_ch0_low_out,
  input wire [11:0] ext_ref_temp_ch0_high_out, onchip_ref_temp_ch0_high_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // ---------------------------------------------------------------
  // Read port timing and decode
  // ---------------------------------------------------------------
  rd_answer_a: assert property (rd_en_in |=> rvalid_out)
    else $error("read strobe got no answer");
  rd_spur_a: assert property (!rd_en_in |=> !rvalid_out && $stable(rdata_out))
    else $error("read data moved without a read");
  unmap_zero_a: assert property (rd_en_in && !hit_out |=> rdata_out == 24'h000000)
    else $error("unmapped read not zero");
  hit_map_a: assert property (hit_out == (addr_in >= 8'h45 && addr_in < 8'h45 + NUM_REGS))
    else $error("decode wrong");
  // ---------------------------------------------------------------
  // Enable copy, coefficient gating, and 47h/48h field outputs against what the host reads
  // ---------------------------------------------------------------
  corr_copy_a: assert property (temp_corr_active_out == temp_correction_enable_in)
    else $error("enable copy wrong");
  coeff_gate_a: assert property (!temp_correction_enable_in |=>
    onchip_phase_coeff_ch0_low_out == 12'h000 && ext_phase_coeff_ch0_low_out == 12'h000)
    else $error("coefficient leaked while disabled");
  ch0_low_a: assert property (rd_en_in && addr_in == 8'h47 |=>
    rdata_out == {ext_ref_temp_ch0_low_out, onchip_ref_temp_ch0_low_out})
    else $error("47h fields differ");
  ch0_high_a: assert property (rd_en_in && addr_in == 8'h48 |=>
    rdata_out == {ext_ref_temp_ch0_high_out, onchip_ref_temp_ch0_high_out})
    else $error("48h fields differ");
  // Main scenarios
  cover property (rd_en_in && !hit_out);
  cover property (rd_en_in && addr_in == 8'h47);
  cover property (temp_correction_enable_in && onchip_phase_coeff_ch0_low_out != 12'h000);
endmodule // ptc_calib_regs_chk

// File: verif/ptc_host_model.sv
// Purpose: Host side of the register port
// Assumes: Requests move at the falling edge
// Notes:   Data lines show the inverse once released
`timescale 1ns/1ns
module ptc_host_model (
  input wire mclk_in,
  input wire rvalid_in,
  input wire [23:0] rdata_in,
  output reg [7:0] addr_out,
  output reg wr_en_out,
  output reg rd_en_out,
  output reg [23:0] wdata_out
);
  initial {addr_out, wr_en_out, rd_en_out, wdata_out} = 34'h0;
  // One-cycle write strobe; stale data is not left on the lines
  task wr(input [7:0] a, input [23:0] v);
    @(negedge mclk_in);
    addr_out = a;
    wdata_out = v;
    wr_en_out = 1'b1;
    @(negedge mclk_in);
    wr_en_out = 1'b0;
    wdata_out = ~v;
  endtask
  // Answer is due exactly one cycle after the strobe
  task rd(input [7:0] a, output [23:0] v, output ok);
    @(negedge mclk_in);
    addr_out = a;
    rd_en_out = 1'b1;
    @(negedge mclk_in);
    rd_en_out = 1'b0;
    ok = rvalid_in;
    v = rdata_in;
  endtask
endmodule // ptc_host_model

// File: verif/ptc_calib_regs_tb_top.sv
// Purpose: Self-checking bench for the calibration bank
// Assumes: 50 MHz clock, inputs move at the falling edge
// Notes:   Every access goes through the host model
`timescale 1ns/1ns
module ptc_calib_regs_tb_top;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic temp_correction_enable_in = 1'b0;
  logic wr_en_in, rd_en_in, rvalid_out, hit_out, temp_corr_active_out, ok;
  logic [7:0] addr_in;
  logic [23:0] wdata_in, rdata_out, d;
  logic [11:0] onchip_ref_temp_ch2_high_out, onchip_phase_coeff_ch0_low_out;
  logic [11:0] ext_ref_temp_ch2_high_out, ext_phase_coeff_ch0_low_out, ext_ref_temp_ch0_low_out;
  logic [11:0] onchip_ref_temp_ch0_low_out, ext_ref_temp_ch0_high_out;
  logic [11:0] onchip_ref_temp_ch0_high_out, ext_ref_temp_ch1_low_out, onchip_ref_temp_ch1_low_out;
  integer n_fail = 0, compares = 0, i;
  ptc_calib_regs i_ptc_calib_regs (.*);
  ptc_host_model i_ptc_host_model (.mclk_in, .rvalid_in(rvalid_out), .rdata_in(rdata_out),
    .addr_out(addr_in), .wr_en_out(wr_en_in), .rd_en_out(rd_en_in), .wdata_out(wdata_in));
  initial forever #10 mclk_in = ~mclk_in;
  // Distinct word per register so a swapped offset shows
  function automatic logic [23:0] wv(input integer k);
    return 24'ha5c3e1 + 24'(k) * 24'h010203;
  endfunction
  task chk(input [23:0] seen, input [23:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // A missing answer ends the run rather than hanging
  task rdc(input [7:0] a, input [23:0] e);
    i_ptc_host_model.rd(a, d, ok);
    chk({23'h0, ok}, 24'h000001);
    if (ok !== 1'b1) complete_run();
    chk(d, e);
  endtask
  initial begin
    repeat (3) @(negedge mclk_in);
    rst_n_in = 1'b1;
    for (i = 0; i < 5; i++) rdc(8'(69 + i), i == 2 ? 24'h800800 : 24'h0);
    chk(ext_ref_temp_ch0_low_out, 24'h000800);
    $display("test reset values done");
    for (i = 0; i < 5; i++) i_ptc_host_model.wr(8'(69 + i), wv(i));
    for (i = 0; i < 5; i++) rdc(8'(69 + i), wv(i));
    chk(onchip_ref_temp_ch2_high_out, wv(0) >> 12);
    chk(ext_ref_temp_ch2_high_out, wv(1) >> 12);
    chk({ext_ref_temp_ch0_low_out, onchip_ref_temp_ch0_low_out}, wv(2));
    chk({ext_ref_temp_ch0_high_out, onchip_ref_temp_ch0_high_out}, wv(3));
    chk({ext_ref_temp_ch1_low_out, onchip_ref_temp_ch1_low_out}, wv(4));
    chk(onchip_phase_coeff_ch0_low_out, 24'h0);
    i_ptc_host_model.wr(8'h4a, 24'hffffff);
    rdc(8'h44, 24'h0);
    rdc(8'h4a, 24'h0);
    $display("test write readback done");
    // Correction is switched on only after every value is loaded
    temp_correction_enable_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    chk(onchip_phase_coeff_ch0_low_out, wv(0) & 24'h000fff);
    chk(ext_phase_coeff_ch0_low_out, wv(1) & 24'h000fff);
    $display("test correction enable done");
    complete_run();
  end
endmodule // ptc_calib_regs_tb_top
bind ptc_calib_regs ptc_calib_regs_chk #(.NUM_REGS(NUM_REGS)) i_ptc_calib_regs_chk (.*);
